//--- sac_pkg.sv
/*
  Shared constants, control-word layout and state types for the serial
  SAR converter control logic. Assumes a single system clock domain.
  // Operation
  // [R01] Serial input bit is taken into the shift register on serial clock rise.
  // [R02] Serial input is ignored while chip select is high.
  // [R03] Serial output changes only after a serial clock rise.
  // [R04] Data output and strobe output float while chip select is high.
  // [R05] Strobe is high for one serial clock period before the top bit decision.
  // [R06] Low shutdown input forces power-down regardless of serial traffic.
  // [R07] Master keeps serial clock duty between 40 and 60 percent.
  // [R08] Single-ended: selected channel to positive input, common pin to negative.
  // [R09] Differential: inputs only from pairs 0/1, 2/3, 4/5, 6/7.
  // [R10] Acquisition lasts three serial cycles, ends on fall after last bit.
  // [R11] Tracking starts on fall after bit five, hold after bit eight.
  // [R12] Conversion phase lasts fifteen serial clock periods.
  // [R13] After conversion the hold capacitor tracks the positive input again.
  // [R14] Twelve-bit result, one bit decided per serial clock cycle.
  // [R15] Leading zeros after chip select falls are dropped; first one starts.
  // [R16] Result framed with three leading zeros and one trailing zero.
  // [R17] Bipolar gives two's complement, unipolar gives straight binary.
  // [R18] Polarity bit one selects unipolar, zero selects bipolar.
  // [R19] Control bits are counted from the start bit onward.
*/
package sac_pkg;
  localparam int          RES_W       = 12;
  localparam logic [3:0]  CTRL_BITS   = 4'h8;
  localparam logic [3:0]  TRACK_BIT   = 4'h5;
  localparam logic [1:0]  ACQ_CYCLES  = 2'h3;
  localparam logic [3:0]  STRB_CNT    = 4'h2;
  localparam logic [3:0]  MSB_CNT     = 4'h3;
  localparam logic [3:0]  LSB_CNT     = 4'hE;
  localparam logic [3:0]  CONV_CYCLES = 4'hF;
  localparam logic [3:0]  SAR_TOP_IDX = 4'hB;
  localparam logic [11:0] SAR_MID     = 12'h800;
  localparam logic [11:0] RES_RESET   = 12'h000;
  // control word field positions
  localparam int          F_START     = 7;
  localparam int          F_SEL_HI    = 6;
  localparam int          F_SEL_LO    = 4;
  localparam int          F_POL       = 3;
  localparam int          F_CFG       = 2;
  localparam int          F_PD_HI     = 1;
  localparam int          F_PD_LO     = 0;
  localparam logic [7:0]  CTRL_RESET  = 8'hFF;
  localparam logic [7:0]  CTRL_SEED   = 8'h01;
  // sync order: comp, shutdown_n, din, cs_n, sclk
  localparam int          SYNC_W      = 5;
  localparam logic [4:0]  SYNC_RESET  = 5'h0A;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_CTRL = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_t;

  typedef struct packed {
    sac_state_t  state;
    logic [7:0]  ctrl;
    logic [3:0]  bit_cnt;
    logic [3:0]  conv_cnt;
    logic [1:0]  acq_cnt;
    logic        track;
    logic        strb;
    logic        dout;
    logic        oe_n;
    logic        sclk_q;
    logic        res_vld;
    logic [11:0] result;
  } sac_top_st_t;

  typedef struct packed {
    logic [11:0] trial;
    logic [11:0] res;
    logic [3:0]  idx;
    logic        bip;
  } sac_sar_st_t;

  // other member of a fixed differential pair
  function automatic logic [2:0] sac_pair_mate(input logic [2:0] ch);
    sac_pair_mate = {ch[2:1], ~ch[0]};
  endfunction : sac_pair_mate
endpackage : sac_pkg

//--- sac_sar_if.sv
/*
  Carrier between the sequencer and the approximation register.
  Assumes both ends sit on the same system clock.
*/
`timescale 1ns/1ps
interface sac_sar_if;
  logic        start;
  logic        decide;
  logic        comp;
  logic        bipolar;
  logic [11:0] trial;
  logic [11:0] result;
  modport ctl (output start, output decide, output comp, output bipolar,
               input trial, input result);
  modport eng (input start, input decide, input comp, input bipolar,
               output trial, output result);
endinterface : sac_sar_if

//--- sac_sync.sv
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherence across bits.
*/
`timescale 1ns/1ps
module sac_sync (
  input  wire logic                          mclk_i,
  input  wire logic                          rst_i,
  input  wire logic [sac_pkg::SYNC_W-1:0]    d_i,
  output logic      [sac_pkg::SYNC_W-1:0]    q_o
);
  typedef struct packed {
    logic [sac_pkg::SYNC_W-1:0] s1;
    logic [sac_pkg::SYNC_W-1:0] s2;
  } sac_sync_st_t;

  sac_sync_st_t st_ff;
  sac_sync_st_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= {sac_pkg::SYNC_RESET, sac_pkg::SYNC_RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.s2;
endmodule : sac_sync

//--- sac_sar.sv
/*
  Successive approximation register: trial code for the DAC and the
  settled result. Assumes the sequencer pulses start and decide.
*/
`timescale 1ns/1ps
module sac_sar (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  sac_sar_if.eng    sar
);
  sac_pkg::sac_sar_st_t st_ff;
  sac_pkg::sac_sar_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (sar.start) begin
      nxt_st.trial = sac_pkg::SAR_MID;
      nxt_st.res   = sac_pkg::RES_RESET;
      nxt_st.idx   = sac_pkg::SAR_TOP_IDX;
      nxt_st.bip   = sar.bipolar;
    end else if (sar.decide) begin
      // [R14] one bit per cycle
      nxt_st.res[st_ff.idx]   = sar.comp;
      nxt_st.trial[st_ff.idx] = sar.comp;
      if (st_ff.idx != 4'h0) begin
        nxt_st.trial[4'(st_ff.idx - 4'h1)] = 1'b1;
        nxt_st.idx = 4'(st_ff.idx - 4'h1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{trial: sac_pkg::SAR_MID, res: sac_pkg::RES_RESET,
                 idx: sac_pkg::SAR_TOP_IDX, bip: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sar.trial  = st_ff.trial;
  // [R17] offset binary to two's complement
  assign sar.result = st_ff.bip ? {~st_ff.res[11], st_ff.res[10:0]} : st_ff.res;
endmodule : sac_sar

//--- sac_top.sv
/*
  Serial control of a 12-bit SAR converter: control word intake, track and
  hold sequencing, channel routing, strobe and result shift-out.
  Assumes serial pins are asynchronous to mclk_i and the serial clock is
  well below a quarter of mclk_i; the comparator output is also resynced.
*/
`timescale 1ns/1ps
module sac_top (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  input  wire logic        shutdown_low_in_n_i,
  input  wire logic        comp_i,
  output logic             dout_o,
  output logic             dout_oe_n_o,
  output logic             conversion_strobe_out_o,
  output logic             strobe_oe_n_o,
  output logic [2:0]       pos_channel_o,
  output logic [2:0]       neg_channel_o,
  output logic             neg_to_com_o,
  output logic             hold_capacitor_track_o,
  output logic             hold_capacitor_to_neg_o,
  output logic [11:0]      dac_code_o,
  output logic [1:0]       power_mode_o,
  output logic             shutdown_o,
  output logic [11:0]      result_o,
  output logic             result_valid_o
);
  logic [sac_pkg::SYNC_W-1:0] sync_q;
  logic                       sclk_s;
  logic                       cs_s;
  logic                       din_s;
  logic                       shutdown_low_in_n_s;
  logic                       comp_s;
  logic                       rise_evt;
  logic                       fall_evt;
  logic [3:0]                 cnt_inc;
  logic [3:0]                 conv_inc;
  logic [2:0]                 sel;
  logic                       cfg_sgl;
  logic                       pol_uni;
  logic                       start_p;
  logic                       decide_p;
  logic                       msb_slot;
  logic                       data_slot;

  sac_pkg::sac_top_st_t       st_ff;
  sac_pkg::sac_top_st_t       nxt_st;

  localparam sac_pkg::sac_top_st_t TOP_RESET = '{
    state:    sac_pkg::SAC_IDLE,
    ctrl:     sac_pkg::CTRL_RESET,
    bit_cnt:  4'h0,
    conv_cnt: 4'h0,
    acq_cnt:  2'h0,
    track:    1'b0,
    strb:     1'b0,
    dout:     1'b0,
    oe_n:     1'b1,
    sclk_q:   1'b0,
    res_vld:  1'b0,
    result:   sac_pkg::RES_RESET
  };

  // true when a count lies inside a closed window
  function automatic logic sac_in_window(input logic [3:0] cnt,
                                         input logic [3:0] lo,
                                         input logic [3:0] hi);
    sac_in_window = (cnt >= lo) && (cnt <= hi);
  endfunction : sac_in_window

  // all serial pins and the comparator are asynchronous to mclk_i
  sac_sync sac_sync_inst (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({comp_i, shutdown_low_in_n_i, din_i, cs_n_i, sclk_i}),
    .q_o    (sync_q)
  );

  assign sclk_s   = sync_q[0];
  assign cs_s     = sync_q[1];
  assign din_s    = sync_q[2];
  assign shutdown_low_in_n_s = sync_q[3];
  assign comp_s   = sync_q[4];

  // edges against a registered copy; reset level equals the idle low clock
  assign rise_evt = sclk_s & ~st_ff.sclk_q;
  assign fall_evt = ~sclk_s & st_ff.sclk_q;

  assign cnt_inc  = 4'(st_ff.bit_cnt + 4'h1);
  assign conv_inc = 4'(st_ff.conv_cnt + 4'h1);

  assign sel      = st_ff.ctrl[sac_pkg::F_SEL_HI:sac_pkg::F_SEL_LO];
  assign cfg_sgl  = st_ff.ctrl[sac_pkg::F_CFG];
  // [R18] one selects unipolar
  assign pol_uni  = st_ff.ctrl[sac_pkg::F_POL];

  // [R14] twelve decision slots
  assign msb_slot  = (conv_inc == sac_pkg::MSB_CNT);
  assign data_slot = sac_in_window(conv_inc, sac_pkg::MSB_CNT, sac_pkg::LSB_CNT);

  sac_sar_if sar_bus ();

  assign sar_bus.start   = start_p;
  assign sar_bus.decide  = decide_p;
  assign sar_bus.comp    = comp_s;
  assign sar_bus.bipolar = ~pol_uni;

  sac_sar sac_sar_inst (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .sar    (sar_bus)
  );

  always_comb begin
    nxt_st         = st_ff;
    start_p        = 1'b0;
    decide_p       = 1'b0;
    nxt_st.sclk_q  = sclk_s;
    nxt_st.res_vld = 1'b0;
    // [R04] float while deselected
    nxt_st.oe_n    = cs_s;
    if (!shutdown_low_in_n_s) begin
      // [R06] shutdown aborts any frame
      nxt_st.state    = sac_pkg::SAC_IDLE;
      nxt_st.track    = 1'b0;
      nxt_st.strb     = 1'b0;
      nxt_st.bit_cnt  = 4'h0;
      nxt_st.conv_cnt = 4'h0;
      nxt_st.acq_cnt  = 2'h0;
    end else begin
      case (st_ff.state)
        sac_pkg::SAC_IDLE: begin
          // [R15] leading zeros skipped
          if (rise_evt && !cs_s && din_s) begin
            nxt_st.ctrl    = sac_pkg::CTRL_SEED;
            // [R19] start bit counts as one
            nxt_st.bit_cnt = 4'h1;
            nxt_st.state   = sac_pkg::SAC_CTRL;
          end
        end
        sac_pkg::SAC_CTRL: begin
          if (cs_s) begin
            // [R02] a cut word is dropped
            nxt_st.state   = sac_pkg::SAC_IDLE;
            nxt_st.bit_cnt = 4'h0;
          end else if (rise_evt) begin
            // [R01] bit shifted in
            nxt_st.ctrl    = {st_ff.ctrl[6:0], din_s};
            nxt_st.bit_cnt = cnt_inc;
          end else if (fall_evt) begin
            if (st_ff.bit_cnt == sac_pkg::TRACK_BIT) begin
              // [R11] tracking starts
              nxt_st.track   = 1'b1;
              nxt_st.acq_cnt = 2'h0;
            end else if (st_ff.track && st_ff.bit_cnt > sac_pkg::TRACK_BIT) begin
              // [R10] acquisition cycles
              nxt_st.acq_cnt = 2'(st_ff.acq_cnt + 2'h1);
            end
            if (st_ff.bit_cnt == sac_pkg::CTRL_BITS) begin
              // [R11] hold after last bit
              nxt_st.track    = 1'b0;
              nxt_st.state    = sac_pkg::SAC_CONV;
              nxt_st.conv_cnt = 4'h0;
              nxt_st.strb     = 1'b0;
              start_p         = 1'b1;
            end
          end
        end
        sac_pkg::SAC_CONV: begin
          // [R12] paced by serial clock, not by chip select
          if (rise_evt) begin
            nxt_st.conv_cnt = conv_inc;
            // [R05] one period ahead of msb
            nxt_st.strb     = (conv_inc == sac_pkg::STRB_CNT);
            // [R03] output moves on rise only
            if (data_slot) begin
              decide_p = 1'b1;
              // [R17] msb inverted for two's complement
              nxt_st.dout = (msb_slot && !pol_uni) ? ~comp_s : comp_s;
            end else begin
              // [R16] zero padding around result
              nxt_st.dout = 1'b0;
            end
            if (conv_inc == sac_pkg::CONV_CYCLES) begin
              // [R13] back to tracking
              nxt_st.state   = sac_pkg::SAC_IDLE;
              nxt_st.track   = 1'b1;
              nxt_st.res_vld = 1'b1;
              nxt_st.result  = sar_bus.result;
            end
          end
        end
        default: begin
          nxt_st = TOP_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= TOP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout_o                  = st_ff.dout;
  assign dout_oe_n_o             = st_ff.oe_n;
  assign conversion_strobe_out_o = st_ff.strb;
  assign strobe_oe_n_o           = st_ff.oe_n;
  // [R08] single-ended: selected channel against common
  assign pos_channel_o           = sel;
  assign neg_to_com_o            = cfg_sgl;
  // [R09] differential: fixed pair partner
  assign neg_channel_o           = cfg_sgl ? 3'h0 : sac_pkg::sac_pair_mate(sel);
  assign hold_capacitor_track_o  = st_ff.track;
  assign hold_capacitor_to_neg_o = (st_ff.state == sac_pkg::SAC_CONV);
  assign dac_code_o              = sar_bus.trial;
  assign power_mode_o            = st_ff.ctrl[sac_pkg::F_PD_HI:sac_pkg::F_PD_LO];
  // [R06] level straight from the second sync flop
  assign shutdown_o              = ~shutdown_low_in_n_s;
  assign result_o                = st_ff.result;
  assign result_valid_o          = st_ff.res_vld;

  // [R01] bit taken on rise
  AST_DIN_TAKE: assert property (@(posedge mclk_i) disable iff (rst_i) // [R01]
    (rise_evt && !cs_s && shutdown_low_in_n_s && st_ff.state == sac_pkg::SAC_CTRL)
    |=> (st_ff.ctrl[0] == $past(din_s)))
    else $error("control bit not taken on serial clock rise");

  // [R02] deselected input ignored
  AST_DIN_GATED: assert property (@(posedge mclk_i) disable iff (rst_i) // [R02]
    cs_s |=> $stable(st_ff.ctrl))
    else $error("control word changed while deselected");

  // [R03] output moves after rise
  AST_DOUT_RISE: assert property (@(posedge mclk_i) disable iff (rst_i) // [R03]
    $changed(st_ff.dout) |-> $past(rise_evt))
    else $error("data output changed without a serial clock rise");

  // [R04] float while deselected
  AST_HIZ: assert property (@(posedge mclk_i) disable iff (rst_i) // [R04]
    cs_s |=> (dout_oe_n_o && strobe_oe_n_o))
    else $error("outputs driven while deselected");

  // [R05] strobe starts one slot early
  AST_STRB_ROSE: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
    $rose(st_ff.strb) |-> (st_ff.conv_cnt == sac_pkg::STRB_CNT))
    else $error("strobe rose at wrong count");

  // [R05] strobe ends at msb decision
  AST_STRB_FELL: assert property (@(posedge mclk_i) disable iff (rst_i) // [R05]
    ($fell(st_ff.strb) && $past(shutdown_low_in_n_s)) |-> (st_ff.conv_cnt == sac_pkg::MSB_CNT))
    else $error("strobe fell at wrong count");

  // [R06] shutdown forces idle
  AST_SHUTDOWN_LOW_IN: assert property (@(posedge mclk_i) disable iff (rst_i) // [R06]
    !shutdown_low_in_n_s |=> (st_ff.state == sac_pkg::SAC_IDLE && !st_ff.track))
    else $error("not idle during shutdown");

  // [R09] pair partner only
  AST_PAIR: assert property (@(posedge mclk_i) disable iff (rst_i) // [R09]
    !neg_to_com_o |-> (neg_channel_o == {pos_channel_o[2:1], ~pos_channel_o[0]}))
    else $error("differential input outside fixed pair");

  // [R10] three acquisition cycles
  AST_ACQ: assert property (@(posedge mclk_i) disable iff (rst_i) // [R10]
    ($fell(st_ff.track) && st_ff.state == sac_pkg::SAC_CONV)
    |-> (st_ff.acq_cnt == sac_pkg::ACQ_CYCLES))
    else $error("acquisition window length wrong");

  // [R11] tracking after fifth bit
  AST_TRACK_START: assert property (@(posedge mclk_i) disable iff (rst_i) // [R11]
    (fall_evt && !cs_s && shutdown_low_in_n_s && st_ff.state == sac_pkg::SAC_CTRL
     && st_ff.bit_cnt == sac_pkg::TRACK_BIT) |=> st_ff.track)
    else $error("tracking did not start after fifth bit");

  // [R12] conversion length
  AST_CONV_LEN: assert property (@(posedge mclk_i) disable iff (rst_i) // [R12]
    ($past(st_ff.state) == sac_pkg::SAC_CONV && st_ff.state == sac_pkg::SAC_IDLE
     && $past(shutdown_low_in_n_s)) |-> (st_ff.conv_cnt == sac_pkg::CONV_CYCLES && st_ff.track))
    else $error("conversion ended at wrong count");

  // [R14] result only after conversion
  AST_RES_VLD: assert property (@(posedge mclk_i) disable iff (rst_i) // [R14]
    st_ff.res_vld |-> ($past(st_ff.state) == sac_pkg::SAC_CONV))
    else $error("result valid outside conversion end");
endmodule : sac_top

//--- sac_spi_mst.sv
/*
  Serial master model: drives serial clock, chip select and data input.
  Assumes the caller runs on mclk_i at 8 ns; serial period is 80 ns.
*/
`timescale 1ns/1ps
module sac_spi_mst (
  input  wire logic mclk_i,
  input  wire logic dout_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o
);
  logic [23:0] rx;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
    rx     = 24'h000000;
  end
  task automatic frame(input logic [7:0] ctrl, input int lead);
    logic [23:0] w;
    w = {ctrl, 16'h0000};
    @(negedge mclk_i) cs_n_o = 1'b0;
    for (int i = 0; i < lead + 24; i++) begin
      din_o = (i < lead) ? 1'b0 : w[23 - (i - lead)];
      repeat (5) @(negedge mclk_i);
      sclk_o = 1'b1;
      if (i >= lead) rx = {rx[22:0], dout_i};
      repeat (5) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
    repeat (5) @(negedge mclk_i);
    cs_n_o = 1'b1;
    // idle line wanders so ignored bits are not all equal
    repeat (10) @(negedge mclk_i) din_o = ~din_o;
  endtask : frame
endmodule : sac_spi_mst

//--- tb.sv
/*
  Self-checking bench for sac_top with a serial master model.
  Assumes a 125 MHz system clock and an 80 ns serial clock.
*/
`timescale 1ns/1ps
module tb;
  logic mclk, rst, sclk, cs_n, din, shutdown_low_in_n, comp, dout, dout_oen, strb, strb_oen;
  logic [2:0] pos_ch, neg_ch;
  logic neg_com, res_vld, trk, tneg;
  logic [11:0] res, dac;
  logic [1:0] pmode;
  logic shutdown_low_in;
  int miscompares, n_compared, strb_n, vld_n, conv_n;
  sac_spi_mst sac_spi_mst_inst (.mclk_i(mclk), .dout_i(dout), .sclk_o(sclk),
                                .cs_n_o(cs_n), .din_o(din));
  sac_top sac_top_inst (.mclk_i(mclk), .rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .shutdown_low_in_n_i(shutdown_low_in_n), .comp_i(comp), .dout_o(dout),
    .dout_oe_n_o(dout_oen), .conversion_strobe_out_o(strb), .strobe_oe_n_o(strb_oen),
    .pos_channel_o(pos_ch), .neg_channel_o(neg_ch), .neg_to_com_o(neg_com),
    .hold_capacitor_track_o(trk), .hold_capacitor_to_neg_o(tneg), .dac_code_o(dac),
    .power_mode_o(pmode), .shutdown_o(shutdown_low_in), .result_o(res), .result_valid_o(res_vld));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (strb === 1'b1 && strb_oen === 1'b0) strb_n++;
    if (res_vld === 1'b1) vld_n++;
    if (tneg === 1'b1) conv_n++;
  end
  always @(negedge mclk) comp <= (dac < 12'h5A3);
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic t_single();
    strb_n = 0;
    vld_n = 0;
    conv_n = 0;
    sac_spi_mst_inst.frame(8'hFF, 3);
    chk({9'h000, pos_ch}, 12'h007);
    chk({11'h000, neg_com}, 12'h001);
    chk({11'h000, strb_n >= 8 && strb_n <= 12}, 12'h001);
    chk({11'h000, vld_n > 0}, 12'h001);
    chk(res, 12'h5A2);
    chk(sac_spi_mst_inst.rx[12:1], 12'h5A2);
    chk({9'h000, sac_spi_mst_inst.rx[15:13]}, 12'h000);
    chk({11'h000, sac_spi_mst_inst.rx[0]}, 12'h000);
    chk({11'h000, conv_n >= 140 && conv_n <= 150}, 12'h001);
    chk({11'h000, trk}, 12'h001);
    repeat (4) @(negedge mclk);
    chk({10'h000, dout_oen, strb_oen}, 12'h003);
  endtask : t_single
  task automatic t_diff(input logic [7:0] ctrl, input logic [2:0] p);
    sac_spi_mst_inst.frame(ctrl, 0);
    chk({6'h00, pos_ch, neg_ch}, {6'h00, p, p ^ 3'h1});
    chk({11'h000, neg_com}, 12'h000);
  endtask : t_diff
  task automatic t_shutdown_low_in();
    @(negedge mclk) shutdown_low_in_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk({11'h000, shutdown_low_in}, 12'h001);
    shutdown_low_in_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask : t_shutdown_low_in
  initial begin
    rst = 1'b1;
    shutdown_low_in_n = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk({10'h000, dout_oen, strb_oen}, 12'h003);
    t_single();
    t_diff(8'h8B, 3'h0);
    t_diff(8'hEB, 3'h6);
    t_shutdown_low_in();
    t_single();
    final_report();
  end
endmodule : tb
